// file: frt_regs.svh
// Constants of the free-running capture/compare timer
// How it works
// - Internal source advances counter on falling edge of clock divided by 2, 8, 32.
// - External source advances counter on each rising edge of the count pin.
// - Compare match A or B drives its programmed level onto its output pin.
// - With clear-on-match-A set, match A returns the counter to zero.
// - Each capture input makes a capture pulse on its selected edge.
// - Capture edge during upper-byte read of that register is postponed one cycle.
// - Buffer mode with opposite edge selects captures both edges of primary input.
// - Buffer channel edge still sets its flag and irq, but loads nothing.
// - Buffer mode capture waits one cycle while either pair register's upper byte is read.
// - A channel's capture pulse sets its capture flag.
// - Compare flag sets in last equal cycle, just before the counter moves.
// - Wrap flag sets when the counter goes from all ones to zero.
// - Seven interrupt sources, each gated by its own enable bit.
// - Separate request lines, priority capture A, B, C, D, compare A, B, wrap.
// - Counter clear coinciding with low-byte counter write wins; write is dropped.
// - Count pulse coinciding with low-byte counter write is lost; write is stored.
// - Low-byte compare write coinciding with its match suppresses that match.
// - Clock select switch from high source to low source counts once.
// - Switching between internal and external source may count once too.
// - Clock select 00 divides by 2, 01 by 8, 10 by 32, 11 external.
// - Upper byte writes go to the byte latch; lower byte write commits both to the counter or a compare register.
// - Upper byte read latches lower byte; next lower read returns latched byte.
// - Compare register reads return both bytes directly, bypassing the byte latch.
`ifndef FRT_REGS_SVH
`define FRT_REGS_SVH

// Clock select codes
`define FRT_CKS_DIV2 2'h0
`define FRT_CKS_DIV8 2'h1
`define FRT_CKS_DIV32 2'h2
`define FRT_CKS_EXT 2'h3

// Prescaler taps
`define FRT_DIV_WIDTH 5
`define FRT_DIV2_BIT 0
`define FRT_DIV8_BIT 2
`define FRT_DIV32_BIT 4

// Reset values
`define FRT_COUNTER_RST 16'h0000
`define FRT_COMPARE_RST 16'hFFFF
`define FRT_CAPTURE_RST 16'h0000
`define FRT_ALL_ONES 16'hFFFF

// Flag vector positions
`define FRT_FLAG_CMPA 4
`define FRT_FLAG_CMPB 5
`define FRT_FLAG_WRAP 6

// Timing
`define FRT_SYS_CLK_NS 20
`define FRT_EXT_PULSE_MIN_NS 30
`define FRT_EXT_PULSE_MIN_CYC ((`FRT_EXT_PULSE_MIN_NS + `FRT_SYS_CLK_NS - 1) / `FRT_SYS_CLK_NS)

`endif

// file: frt_pkg.sv
// Types of the free-running capture/compare timer
`default_nettype none
package frt_pkg;
  typedef logic [15:0] word_t;
  typedef enum logic [2:0] {
    SEL_COUNTER = 3'h0,
    SEL_COMPARE_A = 3'h1,
    SEL_COMPARE_B = 3'h2,
    SEL_CAPTURE_A = 3'h3,
    SEL_CAPTURE_B = 3'h4,
    SEL_CAPTURE_C = 3'h5,
    SEL_CAPTURE_D = 3'h6
  } reg_sel_e;
endpackage : frt_pkg
`default_nettype wire

// file: pin_sync_edge.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/100ps
`default_nettype none
module pin_sync_edge (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Pin
  input wire logic pin_i,
  // Filtered level and edges
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;
  logic rise_ff;
  logic fall_ff;

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end
    else
    begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Level moves only once stages two and three agree
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      level_ff <= 1'b0;
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end
    else
    begin
      rise_ff <= (s2_ff == s3_ff) && s3_ff && !level_ff;
      fall_ff <= (s2_ff == s3_ff) && !s3_ff && level_ff;
      if (s2_ff == s3_ff)
        level_ff <= s3_ff;
    end
  end

  assign level_o = level_ff;
  assign rise_o = rise_ff;
  assign fall_o = fall_ff;
endmodule : pin_sync_edge
`default_nettype wire

// file: free_running_capture_compare_timer.sv
// Free-running 16-bit timer with two compares and four captures
`timescale 1ns/100ps
`default_nettype none
`include "frt_regs.svh"
module free_running_capture_compare_timer (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Mode control
  input wire logic clock_select_hi_i,
  input wire logic clock_select_lo_i,
  input wire logic clear_on_match_a_i,
  input wire logic buffer_en_a_i,
  input wire logic buffer_en_b_i,
  input wire logic [3:0] capture_edge_sel_i,
  input wire logic match_level_a_i,
  input wire logic match_level_b_i,
  input wire logic [6:0] irq_enable_i,
  // Pins
  input wire logic ext_count_clock_pin_i,
  input wire logic [3:0] capture_in_i,
  output logic compare_out_a_o,
  output logic compare_out_b_o,
  // CPU byte access
  input wire frt_pkg::reg_sel_e cpu_sel_i,
  input wire logic cpu_hi_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  input wire logic [7:0] cpu_wdata_i,
  output logic [7:0] cpu_rdata_o,
  // Flags
  input wire logic [6:0] flag_clear_i,
  output logic [3:0] capture_flag_o,
  output logic compare_flag_a_o,
  output logic compare_flag_b_o,
  output logic wrap_flag_o,
  // Interrupt requests
  output logic capture_irq_a_o,
  output logic capture_irq_b_o,
  output logic capture_irq_c_o,
  output logic capture_irq_d_o,
  output logic compare_irq_a_o,
  output logic compare_irq_b_o,
  output logic wrap_irq_o,
  output logic [2:0] irq_top_o
);
  import frt_pkg::*;

  // ************************************************************
  // Count clock source
  // ************************************************************
  logic [`FRT_DIV_WIDTH-1:0] div_cnt_ff;
  logic [1:0] cks;
  logic int_level;
  logic src_level;
  logic ext_level;
  logic prev_src_ff;
  logic tick;

  assign cks = {clock_select_hi_i, clock_select_lo_i};

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      div_cnt_ff <= '0;
    else
      div_cnt_ff <= div_cnt_ff + 5'h1;
  end

  pin_sync_edge u_ext_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pin_i(ext_count_clock_pin_i),
    .level_o(ext_level),
    .rise_o(),
    .fall_o()
  );

  // External level is inverted so that every source counts on a fall
  always_comb
  begin
    case (cks)
      `FRT_CKS_DIV2: int_level = div_cnt_ff[`FRT_DIV2_BIT];
      `FRT_CKS_DIV8: int_level = div_cnt_ff[`FRT_DIV8_BIT];
      `FRT_CKS_DIV32: int_level = div_cnt_ff[`FRT_DIV32_BIT];
      default: int_level = 1'b0;
    endcase
    src_level = (cks == `FRT_CKS_EXT) ? !ext_level : int_level;
  end

  // Previous level is of the selected source, so a high-to-low switch counts
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      prev_src_ff <= 1'b0;
    else
      prev_src_ff <= src_level;
  end

  assign tick = prev_src_ff && !src_level;

  // ************************************************************
  // Counter, compares and byte access
  // ************************************************************
  word_t free_counter_ff;
  word_t compare_reg_a_ff;
  word_t compare_reg_b_ff;
  word_t cap_ff [4];
  logic [7:0] temp_ff;
  logic [7:0] rdata_ff;
  logic wr_lo_cnt;
  logic wr_lo_cmp_a;
  logic wr_lo_cmp_b;
  logic match_a;
  logic match_b;
  logic clear_a;
  logic wrap_evt;
  logic compare_out_a_ff;
  logic compare_out_b_ff;
  word_t rd_word;

  assign wr_lo_cnt = cpu_wr_i && !cpu_hi_i && (cpu_sel_i == SEL_COUNTER);
  assign wr_lo_cmp_a = cpu_wr_i && !cpu_hi_i && (cpu_sel_i == SEL_COMPARE_A);
  assign wr_lo_cmp_b = cpu_wr_i && !cpu_hi_i && (cpu_sel_i == SEL_COMPARE_B);

  // Match is taken in the last equal cycle, as the counter is about to move
  assign match_a = tick && (free_counter_ff == compare_reg_a_ff) && !wr_lo_cmp_a;
  assign match_b = tick && (free_counter_ff == compare_reg_b_ff) && !wr_lo_cmp_b;
  assign clear_a = match_a && clear_on_match_a_i;
  assign wrap_evt = tick && (free_counter_ff == `FRT_ALL_ONES) && !clear_a && !wr_lo_cnt;

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      free_counter_ff <= `FRT_COUNTER_RST;
    else if (clear_a)
      free_counter_ff <= `FRT_COUNTER_RST;
    else if (wr_lo_cnt)
      free_counter_ff <= {temp_ff, cpu_wdata_i};
    else if (tick)
      free_counter_ff <= free_counter_ff + 16'h0001;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      compare_reg_a_ff <= `FRT_COMPARE_RST;
      compare_reg_b_ff <= `FRT_COMPARE_RST;
    end
    else
    begin
      if (wr_lo_cmp_a)
        compare_reg_a_ff <= {temp_ff, cpu_wdata_i};
      if (wr_lo_cmp_b)
        compare_reg_b_ff <= {temp_ff, cpu_wdata_i};
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      compare_out_a_ff <= 1'b0;
      compare_out_b_ff <= 1'b0;
    end
    else
    begin
      if (match_a)
        compare_out_a_ff <= match_level_a_i;
      if (match_b)
        compare_out_b_ff <= match_level_b_i;
    end
  end

  assign compare_out_a_o = compare_out_a_ff;
  assign compare_out_b_o = compare_out_b_ff;

  always_comb
  begin
    case (cpu_sel_i)
      SEL_COMPARE_A: rd_word = compare_reg_a_ff;
      SEL_COMPARE_B: rd_word = compare_reg_b_ff;
      SEL_CAPTURE_A: rd_word = cap_ff[0];
      SEL_CAPTURE_B: rd_word = cap_ff[1];
      SEL_CAPTURE_C: rd_word = cap_ff[2];
      SEL_CAPTURE_D: rd_word = cap_ff[3];
      default: rd_word = free_counter_ff;
    endcase
  end

  // One byte latch serves reads and writes; compares bypass it on reads
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      temp_ff <= 8'h00;
      rdata_ff <= 8'h00;
    end
    else if (cpu_wr_i && cpu_hi_i)
      temp_ff <= cpu_wdata_i;
    else if (cpu_rd_i && cpu_hi_i)
    begin
      rdata_ff <= rd_word[15:8];
      if (cpu_sel_i != SEL_COMPARE_A && cpu_sel_i != SEL_COMPARE_B)
        temp_ff <= rd_word[7:0];
    end
    else if (cpu_rd_i)
    begin
      if (cpu_sel_i == SEL_COMPARE_A || cpu_sel_i == SEL_COMPARE_B)
        rdata_ff <= rd_word[7:0];
      else
        rdata_ff <= temp_ff;
    end
  end

  assign cpu_rdata_o = rdata_ff;

  // ************************************************************
  // Input capture
  // ************************************************************
  logic [3:0] pin_rise;
  logic [3:0] pin_fall;
  logic [3:0] rd_hi;
  logic [3:0] raw;
  logic [3:0] block;
  logic [3:0] fire;
  logic [3:0] pend_ff;
  logic [1:0] buf_en;

  assign buf_en = {buffer_en_b_i, buffer_en_a_i};

  genvar n;
  generate
    for (n = 0; n < 4; n++)
    begin : g_cap
      pin_sync_edge u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .pin_i(capture_in_i[n]),
        .level_o(),
        .rise_o(pin_rise[n]),
        .fall_o(pin_fall[n])
      );
      assign rd_hi[n] = cpu_rd_i && cpu_hi_i && (cpu_sel_i == reg_sel_e'(3'(n + 3)));
      if (n < 2)
      begin : g_prim
        // Buffer mode adds the partner's edge select, giving both edges if opposite
        assign raw[n] = (pin_rise[n] && (capture_edge_sel_i[n] ||
                        (buf_en[n] && capture_edge_sel_i[n+2]))) ||
                        (pin_fall[n] && (!capture_edge_sel_i[n] ||
                        (buf_en[n] && !capture_edge_sel_i[n+2])));
        assign block[n] = rd_hi[n] || (buf_en[n] && rd_hi[n+2]);
        always_ff @(posedge sys_clk_i or posedge rst_i)
        begin
          if (rst_i)
            cap_ff[n] <= `FRT_CAPTURE_RST;
          else if (fire[n])
            cap_ff[n] <= free_counter_ff;
        end
      end
      else
      begin : g_buf
        assign raw[n] = (pin_rise[n] && capture_edge_sel_i[n]) ||
                        (pin_fall[n] && !capture_edge_sel_i[n]);
        assign block[n] = rd_hi[n] || (buf_en[n-2] && rd_hi[n-2]);
        always_ff @(posedge sys_clk_i or posedge rst_i)
        begin
          if (rst_i)
            cap_ff[n] <= `FRT_CAPTURE_RST;
          else if (buf_en[n-2] && fire[n-2])
            cap_ff[n] <= cap_ff[n-2];
          else if (!buf_en[n-2] && fire[n])
            cap_ff[n] <= free_counter_ff;
        end
      end
      assign fire[n] = (raw[n] || pend_ff[n]) && !block[n];
      // Postponed pulse waits while the upper byte read persists
      always_ff @(posedge sys_clk_i or posedge rst_i)
      begin
        if (rst_i)
          pend_ff[n] <= 1'b0;
        else
          pend_ff[n] <= (raw[n] || pend_ff[n]) && block[n];
      end
    end
  endgenerate

  // ************************************************************
  // Flags and interrupt requests
  // ************************************************************
  logic [6:0] flags_ff;
  logic [6:0] irq;

  function automatic logic [2:0] top_request(input logic [6:0] req);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 6; i >= 0; i--)
      if (req[i])
        idx = 3'(i + 1);
    return idx;
  endfunction : top_request

  // Set wins over a clear in the same cycle
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      flags_ff <= 7'h00;
    else
      flags_ff <= (flags_ff & ~flag_clear_i) | {wrap_evt, match_b, match_a, fire};
  end

  assign irq = flags_ff & irq_enable_i;
  assign capture_flag_o = flags_ff[3:0];
  assign compare_flag_a_o = flags_ff[`FRT_FLAG_CMPA];
  assign compare_flag_b_o = flags_ff[`FRT_FLAG_CMPB];
  assign wrap_flag_o = flags_ff[`FRT_FLAG_WRAP];
  assign capture_irq_a_o = irq[0];
  assign capture_irq_b_o = irq[1];
  assign capture_irq_c_o = irq[2];
  assign capture_irq_d_o = irq[3];
  assign compare_irq_a_o = irq[`FRT_FLAG_CMPA];
  assign compare_irq_b_o = irq[`FRT_FLAG_CMPB];
  assign wrap_irq_o = irq[`FRT_FLAG_WRAP];
  assign irq_top_o = top_request(irq);

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_div32_tick: assert property ((cks == `FRT_CKS_DIV32 && $stable(cks) && tick)
    |-> div_cnt_ff == 5'h00)
    else $error("div32 count pulse off its prescaler fall");
  a_tick_advance: assert property ((tick && !clear_a && !wr_lo_cnt)
    |=> free_counter_ff == $past(free_counter_ff) + 16'h0001)
    else $error("count pulse did not advance counter");
  a_clear_wins: assert property (clear_a |=> free_counter_ff == 16'h0000)
    else $error("match A clear did not zero counter");
  a_write_beats_tick: assert property ((wr_lo_cnt && !clear_a)
    |=> free_counter_ff == {$past(temp_ff), $past(cpu_wdata_i)})
    else $error("counter write lost");
  a_match_pin: assert property (match_a ##1 !match_a
    |-> compare_out_a_o == $past(match_level_a_i))
    else $error("compare A pin not at programmed level");
  a_compare_gate: assert property ((wr_lo_cmp_a && !flags_ff[4]) |=> !flags_ff[4])
    else $error("compare A flag set during compare write");
  a_capture_hold: assert property ((raw[0] && block[0]) |=> pend_ff[0])
    else $error("blocked capture A not postponed");
  a_buffer_shift: assert property ((fire[0] && buffer_en_a_i)
    |=> cap_ff[2] == $past(cap_ff[0]) && cap_ff[0] == $past(free_counter_ff))
    else $error("buffer shift wrong");
  a_capture_flag: assert property ((fire != 4'h0)
    |=> (flags_ff[3:0] & $past(fire)) == $past(fire))
    else $error("capture flag not set");
  a_wrap_set: assert property (wrap_evt |=> wrap_flag_o && free_counter_ff == 16'h0000)
    else $error("wrap not flagged");
  a_top_first: assert property (capture_irq_a_o |-> irq_top_o == 3'h1)
    else $error("capture A not top request");

  c_wrap: cover property (wrap_evt);
  c_clear_a: cover property (clear_a);
  c_buffer_both: cover property (fire[0] && buffer_en_a_i ##[1:200] fire[0]);
  c_postponed: cover property (raw[1] && block[1]);
endmodule : free_running_capture_compare_timer
`default_nettype wire

// file: ext_pins_model.sv
// Behavioural model of the parties driving the count and capture pins
`timescale 1ns/100ps
`default_nettype none
module ext_pins_model (
  // Clock
  input wire logic sys_clk_i,
  // Pins
  output logic ext_pin_o,
  output logic [3:0] cap_pin_o
);
  initial
  begin
    ext_pin_o = 1'b0;
    cap_pin_o = 4'h0;
  end

  // Each level held 3 cycles so the two-sample filter always agrees
  task automatic pulse_ext();
    @(posedge sys_clk_i);
    ext_pin_o <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    ext_pin_o <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
  endtask : pulse_ext

  task automatic set_cap(input int idx, input logic v);
    @(posedge sys_clk_i);
    cap_pin_o[idx] <= v;
    repeat (3) @(posedge sys_clk_i);
  endtask : set_cap
endmodule : ext_pins_model
`default_nettype wire

// file: free_running_capture_compare_timer_tb.sv
// Self-checking bench for the free-running capture/compare timer
`timescale 1ns/100ps
`default_nettype none
`include "frt_regs.svh"
module free_running_capture_compare_timer_tb;
  import frt_pkg::*;
  typedef struct {string name; logic [7:0] val;} exp_s;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] cks = 2'h0;
  logic clear_a = 1'b0;
  logic buf_a = 1'b0;
  logic [3:0] edge_sel = 4'h0;
  logic lvl_a = 1'b0;
  logic lvl_b = 1'b0;
  logic [6:0] irq_en = 7'h00;
  logic ext_pin;
  logic [3:0] cap_pin;
  logic out_a, out_b, flag_a, flag_b, wrap;
  reg_sel_e sel = SEL_COUNTER;
  logic hi = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [6:0] flag_clr = 7'h00;
  logic [3:0] cap_flag;
  logic [6:0] irq;
  logic [2:0] irq_top;
  exp_s exp_q[$];
  exp_s cur;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  int per;
  // Seed 54207
  logic [15:0] rng = 16'hD3BF;
  logic [15:0] rnd;

  always #10 sys_clk_i = ~sys_clk_i;

  free_running_capture_compare_timer free_running_capture_compare_timer_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .clock_select_hi_i(cks[1]), .clock_select_lo_i(cks[0]),
    .clear_on_match_a_i(clear_a), .buffer_en_a_i(buf_a), .buffer_en_b_i(buf_a),
    .capture_edge_sel_i(edge_sel), .match_level_a_i(lvl_a), .match_level_b_i(lvl_b),
    .irq_enable_i(irq_en), .ext_count_clock_pin_i(ext_pin), .capture_in_i(cap_pin),
    .compare_out_a_o(out_a), .compare_out_b_o(out_b),
    .cpu_sel_i(sel), .cpu_hi_i(hi), .cpu_wr_i(wr), .cpu_rd_i(rd),
    .cpu_wdata_i(wdata), .cpu_rdata_o(rdata), .flag_clear_i(flag_clr),
    .capture_flag_o(cap_flag), .compare_flag_a_o(flag_a), .compare_flag_b_o(flag_b),
    .wrap_flag_o(wrap), .capture_irq_a_o(irq[0]), .capture_irq_b_o(irq[1]),
    .capture_irq_c_o(irq[2]), .capture_irq_d_o(irq[3]), .compare_irq_a_o(irq[4]),
    .compare_irq_b_o(irq[5]), .wrap_irq_o(irq[6]), .irq_top_o(irq_top)
  );

  ext_pins_model ext_pins_model_inst (
    .sys_clk_i(sys_clk_i),
    .ext_pin_o(ext_pin),
    .cap_pin_o(cap_pin)
  );

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] xs();
    rng = rng ^ (rng << 7);
    rng = rng ^ (rng >> 9);
    rng = rng ^ (rng << 8);
    return rng;
  endfunction : xs

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic wr16(input reg_sel_e s, input logic [15:0] v);
    @(posedge sys_clk_i);
    sel <= s;
    hi <= 1'b1;
    wr <= 1'b1;
    wdata <= v[15:8];
    @(posedge sys_clk_i);
    hi <= 1'b0;
    wdata <= v[7:0];
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask : wr16

  // Notes both expected bytes, the monitor compares them as they appear
  task automatic rd16(input reg_sel_e s, input logic [15:0] v, input string name);
    exp_q.push_back('{name, v[15:8]});
    exp_q.push_back('{name, v[7:0]});
    @(posedge sys_clk_i);
    sel <= s;
    hi <= 1'b1;
    rd <= 1'b1;
    @(posedge sys_clk_i);
    hi <= 1'b0;
    @(posedge sys_clk_i);
    rd <= 1'b0;
  endtask : rd16

  task automatic clr_flags();
    @(posedge sys_clk_i);
    flag_clr <= 7'h7F;
    @(posedge sys_clk_i);
    flag_clr <= 7'h00;
  endtask : clr_flags

  task automatic wait_cyc(input int k);
    repeat (k) @(negedge sys_clk_i);
  endtask : wait_cyc

  // Counts edges until compare flag A shows, bounded
  task automatic wait_flag_a(output int m);
    m = 0;
    do
    begin
      @(negedge sys_clk_i);
      m = m + 1;
    end
    while (flag_a !== 1'b1 && m < 400);
  endtask : wait_flag_a

  // ****************************************
  // Read-data monitor and hang guard
  // ****************************************
  always @(posedge sys_clk_i)
  begin
    rd_d <= rd;
    if (rd_d)
    begin
      cur = exp_q.pop_front();
      chk(cur.name, {8'h00, cur.val}, {8'h00, rdata});
    end
  end

  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_count = err_count + 1;
      $display("ERROR timeout expected done seen cycle %0d", cyc);
      give_verdict();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd16(SEL_COMPARE_A, `FRT_COMPARE_RST, "cmp_a_reset");
    rd16(SEL_CAPTURE_A, `FRT_CAPTURE_RST, "cap_a_reset");
    // Counter parked on the idle count pin so values stay exact
    @(posedge sys_clk_i);
    cks <= `FRT_CKS_EXT;
    wr16(SEL_COUNTER, 16'h0000);
    rd16(SEL_COUNTER, 16'h0000, "counter");
    rnd = xs();
    wr16(SEL_COMPARE_B, rnd);
    rd16(SEL_COMPARE_B, rnd, "cmp_b");
    wr16(SEL_CAPTURE_A, 16'hBEEF);
    rd16(SEL_CAPTURE_A, 16'h0000, "cap_a_ro");
    wr16(SEL_COUNTER, 16'hFFFE);
    irq_en <= 7'h40;
    ext_pins_model_inst.pulse_ext();
    wait_cyc(6);
    chk("wrap_early", 16'h0000, {15'h0000, wrap});
    ext_pins_model_inst.pulse_ext();
    wait_cyc(6);
    chk("wrap", 16'h0001, {15'h0000, wrap});
    chk("wrap_irq", 16'h0001, {15'h0000, irq[6]});
    chk("irq_top_wrap", 16'h0007, {13'h0000, irq_top});
    rd16(SEL_COUNTER, 16'h0000, "counter_ext");
    irq_en <= 7'h00;
    wait_cyc(2);
    chk("irq_masked", 16'h0000, {6'h00, irq_top, irq});
    // Capture on the rising edge, falling edge ignored
    @(posedge sys_clk_i);
    irq_en <= 7'h7F;
    edge_sel <= 4'h1;
    rnd = xs();
    wr16(SEL_COUNTER, rnd);
    ext_pins_model_inst.set_cap(0, 1'b1);
    // Upper read lands on the edge pulse, so the capture waits a cycle
    rd16(SEL_CAPTURE_A, 16'h0000, "cap_a_busy");
    wait_cyc(6);
    chk("cap_flag", 16'h0001, {12'h000, cap_flag});
    chk("irq_top_cap", 16'h0001, {13'h0000, irq_top});
    rd16(SEL_CAPTURE_A, rnd, "cap_a");
    clr_flags();
    ext_pins_model_inst.set_cap(0, 1'b0);
    wait_cyc(6);
    chk("cap_flag_fall", 16'h0000, {12'h000, cap_flag});
    @(posedge sys_clk_i);
    // Buffer mode, A rising and C falling: both edges of pin A capture
    buf_a <= 1'b1;
    wr16(SEL_COUNTER, 16'h0200);
    ext_pins_model_inst.set_cap(0, 1'b1);
    wait_cyc(6);
    wr16(SEL_COUNTER, 16'h0300);
    ext_pins_model_inst.set_cap(0, 1'b0);
    wait_cyc(6);
    rd16(SEL_CAPTURE_A, 16'h0300, "buf_a");
    rd16(SEL_CAPTURE_C, 16'h0200, "buf_c");
    clr_flags();
    ext_pins_model_inst.set_cap(2, 1'b1);
    ext_pins_model_inst.set_cap(2, 1'b0);
    wait_cyc(6);
    chk("buf_c_flag", 16'h0004, {12'h000, cap_flag});
    rd16(SEL_CAPTURE_C, 16'h0200, "buf_c_kept");
    // Match period with clear on A: (3 + 1) counts of each prescaler
    buf_a <= 1'b0;
    wr16(SEL_COUNTER, 16'h0000);
    wr16(SEL_COMPARE_A, 16'h0003);
    wr16(SEL_COMPARE_B, 16'h0002);
    clear_a <= 1'b1;
    lvl_b <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      @(posedge sys_clk_i);
      cks <= i[1:0];
      lvl_a <= ~i[0];
      clr_flags();
      wait_flag_a(n);
      clr_flags();
      wait_flag_a(n);
      per = n + 1;
      chk("match_period", 16'(8 << (2 * i)), per[15:0]);
      chk("compare_pin", {15'h0000, ~i[0]}, {15'h0000, out_a});
    end
    // Counter passes 2 on its way to 3, so compare B fired since the last clear
    chk("cmp_b_flag", 16'h0001, {15'h0000, flag_b});
    chk("compare_pin_b", 16'h0001, {15'h0000, out_b});
    chk("irq_top_cmp", 16'h0005, {13'h0000, irq_top});
    give_verdict();
  end
endmodule : free_running_capture_compare_timer_tb
`default_nettype wire
